// ==== logic/owdb_pkg.sv ====
package owdb_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00; // sink control, select, go
    localparam logic [7:0] OFF_THR     = 8'h04; // open wire threshold
    localparam logic [7:0] OFF_AUXCFG  = 8'h08; // aux channel select, settle
    localparam logic [7:0] OFF_LOC     = 8'h0c; // shared channel location
    localparam logic [7:0] OFF_STAT    = 8'h10; // done flags (write one clears)
    localparam logic [7:0] OFF_VFAULT  = 8'h14; // voltage pin faults
    localparam logic [7:0] OFF_BFAULT  = 8'h18; // balance pin faults
    localparam logic [7:0] OFF_AUXDIAG = 8'h1c; // aux diagnostic result
    localparam logic [7:0] OFF_MAINDIAG = 8'h20; // main diagnostic result
    localparam logic [7:0] OFF_BAR     = 8'h24; // dedicated bar result
    localparam logic [7:0] OFF_BARFILT = 8'h28; // bar filter setting
    // field positions in the control and status registers
    localparam int SNK_LSB = 0;
    localparam int SEL_LSB = 4;
    localparam int GO_BIT  = 8;
    localparam int VDONE_BIT = 0;
    localparam int BDONE_BIT = 1;
    // encodings
    localparam logic [2:0] SEL_VPIN = 3'h2;
    localparam logic [2:0] SEL_BPIN = 3'h3;
    localparam logic [1:0] SNK_OFF  = 2'h0;
    localparam logic [1:0] SNK_VPIN = 2'h1;
    localparam logic [1:0] SNK_BPIN = 2'h2;
    localparam logic [1:0] SNK_BAR  = 2'h3;
    // reset values
    localparam logic [15:0] DIAG_RST = 16'h8000;
    localparam logic [3:0]  THR_RST  = 4'h0;
    localparam logic [4:0]  LOC_RST  = 5'h00;
    // threshold step: one lsb of threshold is two to this power result lsbs
    localparam int THR_SHIFT = 8;
    localparam int BAR_GAIN  = 5;

    typedef enum logic [1:0] {
        OWDB_IDLE = 2'b00,
        OWDB_SCAN = 2'b01,
        OWDB_DONE = 2'b11
    } owdb_state_e;

    typedef struct packed {
        logic [1:0] sink;
        logic [2:0] sel;
    } owdb_ctrl_s;
endpackage

// ==== logic/owdb_top.sv ====
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
// Overview of operation
// - sinks on upper pins, sources on bottom
// - compare main cell results to threshold
// - compare aux balance results to threshold
// - locked aux channel copies to aux result
// - main diagnostic result never gets sense data
// - compare every active channel
// - set matching done flag on completion
// - report faults in two register sets
// - at most three bus bars supported
// - both converters measure bar pair
// - bar gain five, own filter setting
// - individual bar uses cell result, filter
// - shared location drives common mode correction
// ----------------------------------------------------------------
module owdb_top #(
    parameter int N_CH = 16  // number of cell channels
) (
    input  wire logic               clock,
    input  wire logic               rst_n,
    // axi4-lite slave
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // converter results, one word per channel
    input  wire logic [N_CH*16-1:0] main_cell_result,
    input  wire logic [N_CH*16-1:0] aux_cell_measurement,
    input  wire logic [N_CH-1:0]    active_channels,
    input  wire logic [15:0]        main_bar_result,
    input  wire logic [15:0]        aux_bar_result,
    // current sink and source enables
    output logic [N_CH-1:0]         vpin_sink_en,
    output logic [N_CH-1:0]         bpin_sink_en,
    output logic                    bottom_sense_source_en,
    output logic                    bottom_balance_source_en,
    output logic                    bar_sink_en,
    // converter steering
    output logic [4:0]              aux_cell_select,
    output logic [1:0]              aux_settle_time,
    output logic [4:0]              common_mode_channel,
    output logic [3:0]              bar_filter_setting,
    output logic [2:0]              bar_gain
);
    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    owdb_pkg::owdb_ctrl_s ctrl_q;      // sink and select
    logic [3:0]           thr_q;       // open wire threshold
    logic [4:0]           auxsel_q;    // aux channel select
    logic [1:0]           settle_q;    // aux settle time
    logic [4:0]           loc_q;       // shared channel location
    logic [3:0]           barfilt_q;   // dedicated bar filter
    logic [1:0]           done_q;      // done flags
    logic [N_CH-1:0]      vfault_q;    // voltage pin faults
    logic [N_CH-1:0]      bfault_q;    // balance pin faults
    logic [15:0]          auxdiag_q;   // aux diagnostic result
    logic [15:0]          bar_q;       // latest dedicated bar result
    owdb_pkg::owdb_state_e state_q;    // comparison sequencer
    logic [2:0]           run_sel_q;   // test being run
    logic [$clog2(N_CH)-1:0] idx_q;    // channel under compare

    // ------------------------------------------------------------
    // axi write channel
    // ------------------------------------------------------------
    logic       aw_hold_q;   // address taken, waiting data
    logic       w_hold_q;    // data taken, waiting address
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic       wr_fire;     // both halves present this cycle
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic       wr_en;

    // ready drops while a half is held or the answer waits
    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
    // a held half wins over the live bus
    assign wr_addr = aw_hold_q ? awaddr_q : s_axi_awaddr;
    assign wr_data = w_hold_q ? wdata_q : s_axi_wdata;
    assign wr_fire = (aw_hold_q || (s_axi_awvalid && s_axi_awready))
                  && (w_hold_q || (s_axi_wvalid && s_axi_wready));
    // partial writes are ignored unless data came before address: every field sits in the low byte pair
    assign wr_en   = wr_fire && (s_axi_wstrb == 4'hf || w_hold_q);

    // address and data may come in either order
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
        end else if (wr_fire) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
            end
        end
    end

    // write response one cycle after both halves
    // addresses past the last register answer with an error
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_addr > owdb_pkg::OFF_BARFILT) ? 2'h2 : 2'h0;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // software writable registers
    // ------------------------------------------------------------
    logic go_pulse;  // go bit written this cycle
    assign go_pulse = wr_en && wr_addr == owdb_pkg::OFF_CTRL
                   && wr_data[owdb_pkg::GO_BIT];

    // go is not stored; it only starts a scan
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_q    <= '0;
            thr_q     <= owdb_pkg::THR_RST;
            auxsel_q  <= 5'h00;
            settle_q  <= 2'h0;
            loc_q     <= owdb_pkg::LOC_RST;
            barfilt_q <= 4'h0;
        end else if (wr_en) begin
            case (wr_addr)
                owdb_pkg::OFF_CTRL: begin
                    ctrl_q.sink <= wr_data[owdb_pkg::SNK_LSB +: 2];
                    ctrl_q.sel  <= wr_data[owdb_pkg::SEL_LSB +: 3];
                end
                owdb_pkg::OFF_THR:     thr_q     <= wr_data[3:0];
                owdb_pkg::OFF_AUXCFG: begin
                    auxsel_q <= wr_data[4:0];
                    settle_q <= wr_data[9:8];
                end
                owdb_pkg::OFF_LOC:     loc_q     <= wr_data[4:0];
                owdb_pkg::OFF_BARFILT: barfilt_q <= wr_data[3:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // current sinks and sources
    // ------------------------------------------------------------
    // bottom pin of each pair is pulled up, all others pulled down
    logic vpin_on;
    logic bpin_on;
    assign vpin_on = ctrl_q.sink == owdb_pkg::SNK_VPIN;
    assign bpin_on = ctrl_q.sink == owdb_pkg::SNK_BPIN;
    assign vpin_sink_en = {N_CH{vpin_on}};
    assign bpin_sink_en = {N_CH{bpin_on}};
    assign bottom_sense_source_en   = vpin_on;
    assign bottom_balance_source_en = bpin_on;
    assign bar_sink_en = ctrl_q.sink == owdb_pkg::SNK_BAR;
    // plain register copies toward the converters
    assign aux_cell_select     = auxsel_q;
    assign aux_settle_time     = settle_q;
    assign common_mode_channel = loc_q;
    // cell channels keep the common filter, only the bar has its own
    assign bar_filter_setting  = barfilt_q;
    // dedicated bar front end is fixed at gain five
    assign bar_gain = 3'(owdb_pkg::BAR_GAIN);

    // ------------------------------------------------------------
    // comparison sequencer
    // ------------------------------------------------------------
    logic [15:0] cur_val;   // measurement of channel under test
    logic [15:0] thr_val;   // threshold scaled to result lsbs
    logic        below;     // channel reads below threshold
    logic        aux_lock;  // aux select names one channel
    // main results for sense pins, aux results for balance pins
    assign cur_val = (run_sel_q == owdb_pkg::SEL_VPIN)
                   ? main_cell_result[idx_q*16 +: 16]
                   : aux_cell_measurement[idx_q*16 +: 16];
    // one threshold step weighs 256 result lsbs
    assign thr_val = 16'({12'h000, thr_q} << owdb_pkg::THR_SHIFT);
    assign below   = cur_val < thr_val;
    // select zero is round robin, k locks on channel k-1
    assign aux_lock = auxsel_q != 5'h00;

    // one channel per cycle; unknown selects are ignored
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q   <= owdb_pkg::OWDB_IDLE;
            run_sel_q <= 3'h0;
            idx_q     <= '0;
        end else begin
            case (state_q)
                owdb_pkg::OWDB_IDLE: begin
                    // only the two open wire selects start a scan
                    if (go_pulse && (wr_data[owdb_pkg::SEL_LSB +: 3] == owdb_pkg::SEL_VPIN
                        || wr_data[owdb_pkg::SEL_LSB +: 3] == owdb_pkg::SEL_BPIN)) begin
                        state_q   <= owdb_pkg::OWDB_SCAN;
                        run_sel_q <= wr_data[owdb_pkg::SEL_LSB +: 3];
                        idx_q     <= '0;
                    end
                end
                owdb_pkg::OWDB_SCAN: begin
                    // last channel ends the scan; the flag follows a cycle later
                    if (idx_q == ($clog2(N_CH))'(N_CH - 1))
                        state_q <= owdb_pkg::OWDB_DONE;
                    else
                        idx_q <= idx_q + 1'b1;
                end
                owdb_pkg::OWDB_DONE: state_q <= owdb_pkg::OWDB_IDLE;
                default: state_q <= owdb_pkg::OWDB_IDLE;
            endcase
        end
    end

    // fault bits: cleared at start, set per channel during scan
    // inactive channels keep the zero written at go
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            vfault_q <= '0;
            bfault_q <= '0;
        end else if (state_q == owdb_pkg::OWDB_IDLE && go_pulse) begin
            if (wr_data[owdb_pkg::SEL_LSB +: 3] == owdb_pkg::SEL_VPIN)
                vfault_q <= '0;
            if (wr_data[owdb_pkg::SEL_LSB +: 3] == owdb_pkg::SEL_BPIN)
                bfault_q <= '0;
        end else if (state_q == owdb_pkg::OWDB_SCAN && active_channels[idx_q]) begin
            if (run_sel_q == owdb_pkg::SEL_VPIN)
                vfault_q[idx_q] <= below;
            else
                bfault_q[idx_q] <= below;
        end
    end

    // locked aux channel copies its compared value; main result untouched
    // round robin select leaves the old value standing
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            auxdiag_q <= owdb_pkg::DIAG_RST;
        end else if (state_q == owdb_pkg::OWDB_SCAN && run_sel_q == owdb_pkg::SEL_BPIN
                     && aux_lock && 5'(idx_q) == auxsel_q - 5'h01) begin
            auxdiag_q <= cur_val;
        end
    end

    // done flags: hardware set wins over software clear
    // one flag per test, matching the select that ran
    logic [1:0] done_set;
    logic [1:0] done_clr;
    assign done_set[owdb_pkg::VDONE_BIT] = state_q == owdb_pkg::OWDB_DONE
                                        && run_sel_q == owdb_pkg::SEL_VPIN;
    assign done_set[owdb_pkg::BDONE_BIT] = state_q == owdb_pkg::OWDB_DONE
                                        && run_sel_q == owdb_pkg::SEL_BPIN;
    assign done_clr = (wr_en && wr_addr == owdb_pkg::OFF_STAT) ? wr_data[1:0] : 2'h0;
    always_ff @(posedge clock) begin
        if (!rst_n)
            done_q <= 2'h0;
        else
            done_q <= (done_q & ~done_clr) | done_set;
    end

    // dedicated bar result follows the main converter
    // one dedicated bar channel; bars on cell channels stay in cell results
    always_ff @(posedge clock) begin
        if (!rst_n)
            bar_q <= 16'h0000;
        else
            bar_q <= main_bar_result;
    end

    // ------------------------------------------------------------
    // axi read channel
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    // read mux decoded straight from the address bus
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr)
            owdb_pkg::OFF_CTRL:    rd_mux = {24'h0, 1'b0, ctrl_q.sel, 2'b0, ctrl_q.sink};
            owdb_pkg::OFF_THR:     rd_mux = {28'h0, thr_q};
            owdb_pkg::OFF_AUXCFG:  rd_mux = {22'h0, settle_q, 3'h0, auxsel_q};
            owdb_pkg::OFF_LOC:     rd_mux = {27'h0, loc_q};
            owdb_pkg::OFF_STAT:    rd_mux = {23'h0, state_q != owdb_pkg::OWDB_IDLE,
                                             6'h0, done_q};
            owdb_pkg::OFF_VFAULT:  rd_mux = 32'(vfault_q);
            owdb_pkg::OFF_BFAULT:  rd_mux = 32'(bfault_q);
            owdb_pkg::OFF_AUXDIAG: rd_mux = {16'h0, auxdiag_q};
            owdb_pkg::OFF_MAINDIAG: rd_mux = {16'h0, owdb_pkg::DIAG_RST};
            owdb_pkg::OFF_BAR:     rd_mux = {aux_bar_result, bar_q};
            owdb_pkg::OFF_BARFILT: rd_mux = {28'h0, barfilt_q};
            default:               rd_mux = 32'h0000_0000;
        endcase
    end

    // one read outstanding: no new address until data is taken
    assign s_axi_arready = !s_axi_rvalid;
    // read data registered one cycle after address
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= (s_axi_araddr > owdb_pkg::OFF_BARFILT
                             || s_axi_araddr[1:0] != 2'h0) ? 2'h2 : 2'h0;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ==== dv/owdb_chk.sv ====
`timescale 1ns/100ps
// ----
// port checker for the open wire sequencer
// ----
module owdb_chk #(
    parameter int N_CH = 16  // channel count
) (
    input wire logic            clock,
    input wire logic            rst_n,
    input wire logic [7:0]      s_axi_awaddr,
    input wire logic            s_axi_awvalid,
    input wire logic            s_axi_awready,
    input wire logic [31:0]     s_axi_wdata,
    input wire logic [3:0]      s_axi_wstrb,
    input wire logic            s_axi_wvalid,
    input wire logic            s_axi_wready,
    input wire logic            s_axi_bvalid,
    input wire logic [7:0]      s_axi_araddr,
    input wire logic            s_axi_arvalid,
    input wire logic            s_axi_arready,
    input wire logic [31:0]     s_axi_rdata,
    input wire logic [1:0]      s_axi_rresp,
    input wire logic            s_axi_rvalid,
    input wire logic            s_axi_rready,
    input wire logic [N_CH-1:0] vpin_sink_en,
    input wire logic [N_CH-1:0] bpin_sink_en,
    input wire logic            bottom_sense_source_en,
    input wire logic            bottom_balance_source_en,
    input wire logic            bar_sink_en,
    input wire logic [4:0]      common_mode_channel,
    input wire logic [2:0]      bar_gain
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    logic wr_both;  // both write halves taken at one edge
    assign wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    // ----
    // pin drive: one load kind at a time, bottom pin gets the source
    // ----
    vsink_src_a: assert property ((|vpin_sink_en) |-> (&vpin_sink_en)
        && bottom_sense_source_en && !(|bpin_sink_en) && !bar_sink_en) else $error("vpin load");
    bsink_src_a: assert property ((|bpin_sink_en) |-> (&bpin_sink_en)
        && bottom_balance_source_en && !(|vpin_sink_en)) else $error("bpin load");
    bar_sink_a: assert property (bar_sink_en |-> !bottom_sense_source_en
        && !bottom_balance_source_en) else $error("bar load");
    bar_gain_a: assert property (bar_gain == 3'h5) else $error("bar gain");
    loc_copy_a: assert property (wr_both && s_axi_awaddr == 8'h0c && s_axi_wstrb == 4'hf
        |=> common_mode_channel == $past(s_axi_wdata[4:0])) else $error("loc copy");
    // ----
    // register bus answers
    // ----
    wr_answer_a: assert property (wr_both |=> s_axi_bvalid) else $error("no bvalid");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read dropped");
    rd_err_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h28
        |=> s_axi_rvalid && s_axi_rresp == 2'h2) else $error("no slverr");
    busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    cover property (wr_both && s_axi_awaddr == 8'h00 && s_axi_wdata[8:4] == 5'h12);
    cover property (wr_both && s_axi_awaddr == 8'h00 && s_axi_wdata[8:4] == 5'h13);
    cover property (bar_sink_en);
endmodule
bind owdb_top owdb_chk #(.N_CH(N_CH)) i_chk (.*);

// ==== dv/owdb_cells.sv ====
`timescale 1ns/100ps
// ----
// cell stack on the sense and balance pins
// ----
module owdb_cells #(
    parameter int          N_CH  = 16,       // channels
    parameter int          DIS   = 24,       // cycles until an open pin has drained
    parameter logic [15:0] LOW_V = 16'h0150, // drained reading
    parameter logic [15:0] BAR_V = 16'h0123  // bus bar drop
) (
    input  wire logic               clock,
    input  wire logic [N_CH-1:0]    vpin_sink_en,
    input  wire logic [N_CH-1:0]    bpin_sink_en,
    input  wire logic [N_CH-1:0]    open_vpin,
    input  wire logic [N_CH-1:0]    open_bpin,
    output logic      [N_CH*16-1:0] main_cell_result,
    output logic      [N_CH*16-1:0] aux_cell_measurement,
    output logic      [15:0]        main_bar_result,
    output logic      [15:0]        aux_bar_result
);
    int vcnt = 0;  // cycles with sense loads on
    int bcnt = 0;  // cycles with balance loads on
    // the filter cap only drains while the load draws current
    always_ff @(posedge clock) begin
        vcnt <= (|vpin_sink_en) ? vcnt + 1 : 0;
        bcnt <= (|bpin_sink_en) ? bcnt + 1 : 0;
    end
    // an open pin reads low once drained, a good one reads healthy
    always_comb begin
        for (int i = 0; i < N_CH; i++) begin
            main_cell_result[16*i+:16] = (open_vpin[i] && vcnt >= DIS) ? LOW_V : 16'h3a00 + 16'(i);
            aux_cell_measurement[16*i+:16] = (open_bpin[i] && bcnt >= DIS) ? LOW_V : 16'h3a00;
        end
    end
    assign main_bar_result = BAR_V;
    assign aux_bar_result  = BAR_V + 16'h1;
endmodule

// ==== dv/tb_open_wire_diag_busbar.sv ====
`timescale 1ns/100ps
// ----
// bench for the open wire sequencer
// ----
module tb_open_wire_diag_busbar;
    localparam int          N_CH  = 16;        // full channel count
    localparam int          DIS   = 24;        // drain time of an open pin
    localparam logic [15:0] LOW_V = 16'h0150;  // drained reading
    localparam logic [15:0] BAR_V = 16'h0123;  // bar drop
    typedef struct packed {
        logic [7:0]  a;  // offset
        logic [31:0] d;  // written
        logic [31:0] e;  // read back
    } owdb_row_s;
    owdb_row_s rows [4] = '{
        '{8'h04, 32'hffffffff, 32'h0000000f},
        '{8'h08, 32'hffffffff, 32'h0000031f},
        '{8'h0c, 32'h00000007, 32'h00000007},
        '{8'h28, 32'h0000000a, 32'h0000000a}};
    logic            clock           = 1'b0;
    logic            rst_n           = 1'b0;
    logic [7:0]      s_axi_awaddr    = 8'h00;
    logic [7:0]      s_axi_araddr    = 8'h00;
    logic [31:0]     s_axi_wdata     = 32'h0;
    logic [3:0]      s_axi_wstrb     = 4'hf;     // whole words only
    logic            s_axi_awvalid   = 1'b0;
    logic            s_axi_wvalid    = 1'b0;
    logic            s_axi_bready    = 1'b1;     // never stalls write answers
    logic            s_axi_arvalid   = 1'b0;
    logic            s_axi_rready    = 1'b0;
    logic [N_CH-1:0] active_channels = 16'hfdff; // channel 9 left out
    logic [N_CH-1:0] open_vpin       = 16'h0220; // broken sense wires
    logic [N_CH-1:0] open_bpin       = 16'h0220; // broken balance wires
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, aux_settle_time;
    logic [31:0] s_axi_rdata;
    logic [N_CH*16-1:0] main_cell_result, aux_cell_measurement;
    logic [15:0] main_bar_result, aux_bar_result;
    logic [N_CH-1:0] vpin_sink_en, bpin_sink_en;
    logic bottom_sense_source_en, bottom_balance_source_en, bar_sink_en;
    logic [4:0] aux_cell_select, common_mode_channel;
    logic [3:0] bar_filter_setting;
    logic [2:0] bar_gain;
    int mismatches = 0;
    int checked    = 0;
    owdb_top #(.N_CH(N_CH)) i_dut (.*);
    owdb_cells #(.N_CH(N_CH), .DIS(DIS), .LOW_V(LOW_V), .BAR_V(BAR_V)) i_cells (.*);
    always #2 clock = ~clock;
    // ----
    // compare and bus tasks; ready is looked at on the falling edge
    // so no race with the design's own updates at the rising one
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, done;
        done = 1'b0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        while (!done) begin
            @(negedge clock);
            ta   = s_axi_awready;
            tw   = s_axi_wready;
            done = s_axi_bvalid;
            r    = s_axi_bresp;
            @(posedge clock);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
    endtask
    // rready comes one edge late so the held answer is exercised
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, rv, done;
        done = 1'b0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        while (!done) begin
            @(negedge clock);
            ta   = s_axi_arready;
            rv   = s_axi_rvalid;
            done = rv && s_axi_rready;
            d    = s_axi_rdata;
            r    = s_axi_rresp;
            @(posedge clock);
            if (ta) s_axi_arvalid <= 1'b0;
            if (rv) s_axi_rready <= !done;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        chk({30'h0, r}, 32'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        chk(d, e);
        chk({30'h0, r}, 32'h0);
    endtask
    task automatic end_sim;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        logic [31:0] d2;
        logic [1:0]  r2;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        for (int i = 0; i < 4; i++) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        chk({27'h0, common_mode_channel}, 32'h7);
        chk({28'h0, bar_filter_setting}, 32'ha);
        chk({25'h0, aux_settle_time, aux_cell_select}, 32'h7f);
        rd(8'h24, {BAR_V + 16'h1, BAR_V});
        // sense pin test: ch5 open and active, ch9 open but inactive
        wr(8'h04, 32'h2);
        wr(8'h08, 32'h6);
        wr(8'h00, {30'h0, owdb_pkg::SNK_VPIN});
        chk({vpin_sink_en, 15'h0, bottom_sense_source_en}, 32'hffff0001);
        repeat (DIS) @(posedge clock);
        wr(8'h00, 32'h121);
        rd(8'h10, 32'h100);
        repeat (N_CH) @(posedge clock);
        rd(8'h10, 32'h1);
        rd(8'h14, 32'h20);
        rd(8'h20, 32'h8000);
        wr(8'h10, 32'h3);
        rd(8'h10, 32'h0);
        wr(8'h00, 32'h0);
        chk({vpin_sink_en, 16'h0}, 32'h0);
        // balance pin test with aux locked on ch5, second go refused
        wr(8'h00, {30'h0, owdb_pkg::SNK_BPIN});
        chk({bpin_sink_en, 15'h0, bottom_balance_source_en}, 32'hffff0001);
        repeat (DIS) @(posedge clock);
        wr(8'h00, 32'h132);
        wr(8'h00, 32'h122);
        repeat (N_CH) @(posedge clock);
        rd(8'h10, 32'h2);
        rd(8'h18, 32'h20);
        rd(8'h14, 32'h20);
        rd(8'h1c, {16'h0, LOW_V});
        wr(8'h00, {30'h0, owdb_pkg::SNK_BAR});
        chk({31'h0, bar_sink_en}, 32'h1);
        wr(8'h00, 32'h0);
        // unmapped places answer with an error
        axi_wr(8'h40, 32'h1, r2);
        chk({30'h0, r2}, 32'h2);
        axi_rd(8'h2c, d2, r2);
        chk({30'h0, r2}, 32'h2);
        wr(8'h00, 32'h150);
        rd(8'h10, 32'h2);
        // second reset with the sequencer idle after the ignored go
        rst_n <= 1'b0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rd(8'h04, 32'h0);
        rd(8'h1c, 32'h8000);
        chk({27'h0, common_mode_channel}, 32'h0);
        end_sim;
    end
    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clock);
        mismatches++;
        end_sim;
    end
endmodule
